/* File: bench/tb_mtpd_top.sv */
`timescale 1ns/100ps
module tb_mtpd_top
  import mtpd_pkg::*;
;
  // Bench drivers and design outputs
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  logic          ce = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h00000000;
  mtpd_word_type comp_in = 24'h333333;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [5:0]    ch_restart;
  logic          sample_tick;
  logic          ch4_start;
  int            n_errors = 0;
  int            total_checks = 0;
  int            c_a;
  int            c_b;

  // 25 MHz clock
  always #20 clk = ~clk;

  // Device under test
  mtpd_top mtpd_top_inst (
    .CLK(clk), .SRST(srst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .COMP_IN(comp_in), .CH_RESTART(ch_restart), .SAMPLE_TICK(sample_tick),
    .CH4_START(ch4_start)
  );

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic give_verdict;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_errors++;
      give_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare a register
  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, addr, 32'h00000000, rd, err);
    check(rd, exp);
    check({31'h00000000, err}, 32'h00000000);
  endtask

  // Delay write: restart mask, clocks from reference tick to channel 4 start, read back
  task automatic wr_code(input logic [31:0] wd, input logic [5:0] mask, output int cyc);
    logic [31:0] rd;
    logic        err;
    logic [5:0]  seen;
    int          i;
    int          ref_at;
    seen = 6'h00;
    ref_at = -1;
    apb(1'b1, 12'h024, wd, rd, err);
    check({31'h00000000, err}, 32'h00000000);
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if (ch_restart !== 6'h00)
        seen = ch_restart;
      else if (seen !== 6'h00 && sample_tick === 1'b1 && ref_at < 0)
        ref_at = i;
      if (ch4_start === 1'b1)
        break;
    end
    if (i == 100)
    begin
      n_errors++;
      give_verdict;
    end
    cyc = i - ref_at;
    check({26'h0000000, seen}, {26'h0000000, mask});
    rd_chk(12'h024, wd & 32'h00000FFF);
  endtask

  // Values after reset
  task automatic t_reset;
    rd_chk(12'h020, 32'h00333333);
    rd_chk(12'h024, 32'h00000000);
    rd_chk(12'h040, 32'h0000003F);
  endtask

  // Comparator nibbles land per channel and follow the pins
  task automatic t_tap;
    // Tap is only read, never written
    comp_in <= 24'h543210;
    repeat (12) @(posedge clk);
    rd_chk(12'h020, 32'h00543210);
    comp_in <= 24'hCBA987;
    repeat (12) @(posedge clk);
    rd_chk(12'h020, 32'h00CBA987);
  endtask

  // Tick spacing, and a low enable freezes the tap
  task automatic t_freeze;
    int i;
    int first;
    first = -1;
    for (i = 0; i < 12; i++)
    begin
      @(posedge clk);
      if (sample_tick === 1'b1)
      begin
        if (first >= 0)
          break;
        first = i;
      end
    end
    check(32'(i - first), 32'h00000004);
    ce <= 1'b0;
    comp_in <= 24'h111111;
    repeat (12) @(posedge clk);
    ce <= 1'b1;
    rd_chk(12'h020, 32'h00CBA987);
  endtask

  // Start spacing grows by four clocks per code step
  task automatic t_phase;
    wr_code(32'hFFFFF002, 6'h3F, c_a);
    wr_code(32'h00000005, 6'h3F, c_b);
    check(32'(c_b - c_a), 32'h0000000C);
  endtask

  // Only active channels restart
  task automatic t_mask;
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 12'h040, 32'h00000035, rd, err);
    wr_code(32'h00000000, 6'h35, c_a);
  endtask

  // Unmapped access is refused and changes nothing
  task automatic t_unmapped;
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 12'h100, 32'h00000777, rd, err);
    check({31'h00000000, err}, 32'h00000001);
    apb(1'b0, 12'h100, 32'h00000000, rd, err);
    check(rd, 32'h00000000);
    check({31'h00000000, err}, 32'h00000001);
    rd_chk(12'h024, 32'h00000000);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_tap;
    t_freeze;
    t_phase;
    t_mask;
    t_unmapped;
    give_verdict;
  end
endmodule

/* File: rtl/mtpd_delay_line.sv */
`timescale 1ns/100ps
`include "mtpd_map.svh"
module mtpd_delay_line
  import mtpd_pkg::*;
(
  // Clock and control
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic          tick,
  input  wire logic          restart,
  input  wire mtpd_code_type code,
  // Reference start and delayed start
  input  wire logic          ref_start,
  output logic               lag_start
);
  typedef struct packed {
    logic          busy;
    mtpd_code_type cnt;
    logic          out;
  } mtpd_dl_state_type;
  mtpd_dl_state_type st_reg;
  mtpd_dl_state_type st_next;

  // Count code sample periods after channel 5 starts, then start channel 4
  always_comb
  begin
    st_next = st_reg;
    st_next.out = 1'b0;
    if (restart)
    begin
      st_next.busy = 1'b0;
      st_next.cnt = '0;
    end
    else if (ref_start)
    begin
      if (code == '0)
        st_next.out = 1'b1; // Zero code: no lag
      else
      begin
        st_next.busy = 1'b1;
        st_next.cnt = code;
      end
    end
    else if (st_reg.busy && tick)
    begin
      st_next.cnt = st_reg.cnt - 12'h001; // One period per count
      if (st_reg.cnt == 12'h001)
      begin
        st_next.busy = 1'b0;
        st_next.out = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign lag_start = st_reg.out;

  lag_count_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !restart && ref_start && code == 12'h002)
      ##1 (ce && !restart && !ref_start && !tick)[*2]
      ##1 (ce && !restart && !ref_start && tick)
      ##1 (ce && !restart && !ref_start && !tick)[*3]
      ##1 (ce && !restart && !ref_start && tick) |=> lag_start)
    else $error("lag start not issued after code periods");
  zero_code_a: assert property (@(posedge clk) disable iff (srst)
    (ce && !restart && ref_start && code == '0) |=> lag_start)
    else $error("zero code did not start at once");
endmodule

/* File: rtl/mtpd_map.svh */
`ifndef MTPD_MAP_SVH
`define MTPD_MAP_SVH
`define MTPD_TAP_INDEX      8'h08
`define MTPD_DELAY_INDEX    8'h09
`define MTPD_CTRL_ADDR      12'h040
`define MTPD_TAP_RESET      24'h333333
`define MTPD_DELAY_RESET    12'h000
`define MTPD_ACTIVE_RESET   6'h3F
`define MTPD_CH5_LSB        20
`define MTPD_CH4_LSB        16
`define MTPD_CH3_LSB        12
`define MTPD_CH2_LSB        8
`define MTPD_CH1_LSB        4
`define MTPD_CH0_LSB        0
`define MTPD_CODE_WIDTH     12
`define MTPD_SAMPLE_DIV     4'h4
`define MTPD_RESTART_CYCLES 4'h2
`endif

/* File: rtl/mtpd_pkg.sv */
package mtpd_pkg;
  typedef enum logic [1:0] {RUN_ST, HOLD_ST, RESTART_ST} mtpd_state_type;
  typedef logic [11:0] mtpd_code_type;
  typedef logic [23:0] mtpd_word_type;
endpackage

/* File: rtl/mtpd_top.sv */
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "mtpd_map.svh"
module mtpd_top
  import mtpd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Modulator comparator pins, four per channel, asynchronous
  input  wire logic [23:0] COMP_IN,
  // Converter channel control
  output logic [5:0]       CH_RESTART,
  output logic             SAMPLE_TICK,
  output logic             CH4_START
);
  // Byte address from register index
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  typedef struct packed {
    logic [23:0]    sync1;
    logic [23:0]    sync2;
    mtpd_word_type  tap;
    mtpd_code_type  code;
    logic [5:0]     active;
    logic [3:0]     div;
    logic           tick;
    mtpd_state_type state;
    logic [3:0]     rcnt;
    logic [5:0]     restart;
    logic           ch5_start;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           lag;
  } mtpd_top_state_type;
  mtpd_top_state_type st_reg;
  mtpd_top_state_type st_next;

  logic        wr_access;
  logic        rd_access;
  logic        lag_start;

  // APB setup phase, answered in one cycle
  // Decode in the setup cycle: a low enable at that edge loses the transfer
  assign wr_access = PSEL && !PENABLE && PWRITE && !st_reg.pready;
  assign rd_access = PSEL && !PENABLE && !PWRITE && !st_reg.pready;

  // Next state of the whole block
  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = COMP_IN;
    st_next.sync2 = st_reg.sync1;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.restart = '0;
    st_next.ch5_start = 1'b0;
    st_next.lag = lag_start && st_reg.active[4]; // Inactive channel 4 stays idle
    // Modulator sample clock divider
    st_next.tick = (st_reg.div == `MTPD_SAMPLE_DIV - 4'h1);
    st_next.div = st_next.tick ? 4'h0 : st_reg.div + 4'h1;
    // Tap refresh every sample period
    if (st_reg.tick)
      st_next.tap = st_reg.sync2; // Lanes per channel
    // Restart sequence for active channels
    case (st_reg.state)
      RUN_ST: ;
      HOLD_ST:
      begin
        st_next.restart = st_reg.active;
        if (st_reg.rcnt == 4'h1)
          st_next.state = RESTART_ST;
        st_next.rcnt = st_reg.rcnt - 4'h1;
      end
      RESTART_ST:
      begin
        // Start on a tick after the pulse, so the pair delay has no phase jitter
        if (st_reg.tick && st_reg.restart == '0)
        begin
          st_next.ch5_start = st_reg.active[5];
          st_next.state = RUN_ST;
        end
      end
      default: st_next.state = RUN_ST;
    endcase
    // Register access, after the sequence so that a new delay write wins
    if (wr_access || rd_access)
    begin
      st_next.pready = 1'b1;
      st_next.prdata = '0;
      if (PADDR == reg_addr(`MTPD_TAP_INDEX))
      begin
        if (rd_access)
          st_next.prdata = {8'h00, st_reg.tap};
        else
          st_next.tap = PWDATA[23:0]; // Overwritten next tick
      end
      else if (PADDR == reg_addr(`MTPD_DELAY_INDEX))
      begin
        if (rd_access)
          st_next.prdata = {20'h00000, st_reg.code};
        else
        begin
          st_next.code = PWDATA[11:0];
          st_next.state = HOLD_ST;
          st_next.rcnt = `MTPD_RESTART_CYCLES;
        end
      end
      else if (PADDR == `MTPD_CTRL_ADDR)
      begin
        if (rd_access)
          st_next.prdata = {26'h0000000, st_reg.active};
        else
          st_next.active = PWDATA[5:0];
      end
      else
        st_next.pslverr = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      // Power-up values of the registers
      st_reg <= '0;
      st_reg.tap <= `MTPD_TAP_RESET;
      st_reg.code <= `MTPD_DELAY_RESET;
      st_reg.active <= `MTPD_ACTIVE_RESET;
      st_reg.state <= RUN_ST;
    end
    else if (CE)
      st_reg <= st_next;
  end

  // Channel 4 start counter
  mtpd_delay_line mtpd_delay_line_inst
  (
    .clk       (CLK),
    .srst      (SRST),
    .ce        (CE),
    .tick      (st_reg.tick),
    .restart   (|st_reg.restart),
    .code      (st_reg.code),
    .ref_start (st_reg.ch5_start),
    .lag_start (lag_start)
  );

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign CH_RESTART = st_reg.restart;
  assign SAMPLE_TICK = st_reg.tick;
  assign CH4_START = st_reg.lag;

  tap_refresh_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.tick && !wr_access) |=> st_reg.tap == $past(st_reg.sync2))
    else $error("tap not refreshed on sample tick");
  ch5_lane_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.tick && !wr_access) |=> st_reg.tap[23:20] == $past(st_reg.sync2[23:20]))
    else $error("channel 5 lane wrong");
  ch2_lane_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.tick && !wr_access) |=> st_reg.tap[11:8] == $past(st_reg.sync2[11:8]))
    else $error("channel 2 lane wrong");
  ch0_lane_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.tick && !wr_access) |=> st_reg.tap[3:0] == $past(st_reg.sync2[3:0]))
    else $error("channel 0 lane wrong");
  // Remaining nibbles of the tap, one per channel
  ch4_lane_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.tick && !wr_access) |=> st_reg.tap[19:16] == $past(st_reg.sync2[19:16]))
    else $error("channel 4 lane wrong");
  ch3_lane_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.tick && !wr_access) |=> st_reg.tap[15:12] == $past(st_reg.sync2[15:12]))
    else $error("channel 3 lane wrong");
  ch1_lane_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.tick && !wr_access) |=> st_reg.tap[7:4] == $past(st_reg.sync2[7:4]))
    else $error("channel 1 lane wrong");
  // Channel 5 starts only on a tick once the reset pulse is over
  ch5_align_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.state == RESTART_ST && !st_reg.tick) |=> !st_reg.ch5_start)
    else $error("channel 5 start off the sample tick");
  restart_end_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && st_reg.state == RESTART_ST) |=> CH_RESTART == '0)
    else $error("restart pulse too long");
  write_restart_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && wr_access && PADDR == 12'h024 && st_reg.active != '0) ##1 CE |=> CH_RESTART != '0)
    else $error("delay write did not restart channels");
  code_store_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && wr_access && PADDR == 12'h024) |=> st_reg.code == $past(PWDATA[11:0]))
    else $error("delay code not stored");
  upper_zero_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && rd_access && PADDR == 12'h024) |=> PRDATA[31:12] == '0)
    else $error("unimplemented delay bits not zero");
  code_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    !(CE && wr_access && PADDR == 12'h024) |=> st_reg.code == $past(st_reg.code))
    else $error("delay code changed without write");
  tick_period_a: assert property (@(posedge CLK) disable iff (SRST)
    (CE && SAMPLE_TICK) ##1 CE[*3] |=> SAMPLE_TICK)
    else $error("sample tick period wrong");
  delay_write_c: cover property (@(posedge CLK) disable iff (SRST)
    CE && wr_access && PADDR == 12'h024);
  tap_read_c: cover property (@(posedge CLK) disable iff (SRST)
    CE && rd_access && PADDR == 12'h020);
  lag_start_c: cover property (@(posedge CLK) disable iff (SRST) CH4_START);
  // Restart pulse and refused access
  restart_c: cover property (@(posedge CLK) disable iff (SRST) CH_RESTART != '0);
  unmapped_c: cover property (@(posedge CLK) disable iff (SRST) PSLVERR);
endmodule
